// ---- spc_regs.svh ----
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define SPC_IDX_AB1 14'h3fef
`define SPC_IDX_SC1 14'h3ff2
`define SPC_IDX_AB0 14'h3ff3
`define SPC_IDX_SC0 14'h3ff6
`define SPC_IDX_TX0 14'h3fe0
`define SPC_IDX_RX0 14'h3fe1
`define SPC_IDX_TX1 14'h3fe2
`define SPC_IDX_RX1 14'h3fe3
`define SPC_IDX_STAT 14'h3fe4

// ----------------------------------------------------------------
// Serial control fields
// ----------------------------------------------------------------
`define SPC_SC_LEN_MSB 3
`define SPC_SC_LEN_LSB 0
`define SPC_SC_FMT_MSB 5
`define SPC_SC_FMT_LSB 4
`define SPC_SC_RESET 16'h0000

// ----------------------------------------------------------------
// Autobuffer control fields
// ----------------------------------------------------------------
`define SPC_AB_RX_EN 0
`define SPC_AB_TX_EN 1
`define SPC_AB_RXI_MSB 4
`define SPC_AB_RXI_LSB 2
`define SPC_AB_RXM_MSB 6
`define SPC_AB_RXM_LSB 5
`define SPC_AB_TXI_MSB 9
`define SPC_AB_TXI_LSB 7
`define SPC_AB_TXM_MSB 11
`define SPC_AB_TXM_LSB 10
`define SPC_AB_RESET 16'h0000

// ----------------------------------------------------------------
// Companding limits
// ----------------------------------------------------------------
`define SPC_ALAW_MAX 16'h0fff
`define SPC_MULAW_MAX 16'h1fde
`define SPC_MULAW_BIAS 16'h0021

`endif

// ---- spc_pkg.sv ----
package spc_pkg;

    // Autobuffer request towards the address generators and data memory
    typedef struct packed {
        logic we;
        logic [2:0] index_sel;
        logic [2:0] modify_sel;
        logic [15:0] wdata;
    } spc_dm_req_t;

    // Answer from data memory
    typedef struct packed {
        logic ack;
        logic wrap;
        logic [15:0] rdata;
    } spc_dm_ack_t;

    typedef enum logic {SPC_AB_IDLE, SPC_AB_WAIT} spc_ab_state_t;

endpackage

// ---- spc_compand_autobuf.sv ----
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "spc_regs.svh"
// What this block does
// R1: One compression and one expansion per cycle; port one waits a cycle on conflict.
// R2: Each port picks its own companding law independently.
// R3: Format field sits at bits 5:4 of each port control register.
// R4: Format 00 zero fill, 01 sign extend, 10 mu-law, 11 A-law.
// R5: Uncompanded short receive words are right-justified, zero-filled or sign-extended.
// R6: Companded receive holds expanded low eight bits, sign-extended to 16.
// R7: Companded transmit write compresses to eight bits, sign-extended to word width.
// R8: Too-large linear input saturates to the largest positive or negative code.
// R9: Compressed value written back; moves to shift register only after compression.
// R10: Transmit register frees when word moves; interrupt after first bit out.
// R11: Software loads next word early enough for compression before external sync.
// R12: Received word copied, expanded in place, then receive interrupt raised.
// R13: Expansion contention delays the receive interrupt only.
// R14: Companding works with port idle; converted value readable one cycle later.
// R15: Autobuffer moves each word between port and data memory in one stolen cycle, no interrupt.
// R16: Overhead cycle stretches while data memory needs wait states.
// R17: Transfer starts only at instruction completion or idle.
// R18: Index advanced by modify circularly; wrap raises the port interrupt.
// R19: Receive wrap after full buffer; transmit wrap when last word loaded.
// R20: Memory DMA wins; then port0 tx, port0 rx, port1 tx, port1 rx.
// R21: Each port has its own autobuffer control with separate rx and tx enables.
// R22: Three-bit index and two-bit modify selects; modify top bit from index.
// R23: Enables clear at reset and reboot; restart only when software sets them.
module spc_compand_autobuf #(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reboot,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Shift register side, index is the port
    input wire logic [1:0] tx_load,
    input wire logic [1:0] tx_msb_sent,
    output logic [1:0] tx_word_valid,
    output logic [1:0][15:0] tx_word,
    input wire logic [1:0] rx_done,
    input wire logic [1:0][15:0] rx_word,
    // Port interrupts to the core
    output logic [1:0] tx_irq,
    output logic [1:0] rx_irq,
    // Core, address generators and data memory
    input wire logic ab_ok,
    input wire logic dma_busy,
    output logic dm_req_valid,
    output spc_pkg::spc_dm_req_t dm_req,
    input wire spc_pkg::spc_dm_ack_t dm_ack
);
    import spc_pkg::*;

    if (ADDR_W < 16) begin : g_addr_w_check
        $error("ADDR_W must be at least 16");
    end

    // ----------------------------------------------------------------
    // Companding functions
    // ----------------------------------------------------------------
    function automatic logic [7:0] spc_compress(input logic [15:0] x, input logic alaw);
        logic neg;
        logic [15:0] mag;
        logic [15:0] sh;
        logic [2:0] seg;
        logic [3:0] amt;
        neg = x[15];
        mag = neg ? (~x + 16'h0001) : x;
        seg = 3'd0;
        if (alaw) begin
            if (mag > `SPC_ALAW_MAX) mag = `SPC_ALAW_MAX; // [R8]
            for (int k = 1; k < 8; k++) begin
                if (mag[k+4]) seg = 3'(k);
            end
            amt = (seg == 3'd0) ? 4'd1 : {1'b0, seg};
            sh = mag >> amt;
            spc_compress = {~neg, seg, sh[3:0]} ^ 8'h55;
        end else begin
            if (mag > `SPC_MULAW_MAX) mag = `SPC_MULAW_MAX; // [R8]
            mag = mag + `SPC_MULAW_BIAS;
            for (int k = 1; k < 8; k++) begin
                if (mag[k+5]) seg = 3'(k);
            end
            amt = {1'b0, seg} + 4'd1;
            sh = mag >> amt;
            spc_compress = ~{neg, seg, sh[3:0]};
        end
    endfunction

    function automatic logic [15:0] spc_expand(input logic [7:0] c, input logic alaw);
        logic [7:0] d;
        logic [15:0] base;
        logic [15:0] t;
        logic neg;
        if (alaw) begin
            d = c ^ 8'h55;
            base = {11'h000, d[3:0], 1'b1};
            t = (d[6:4] == 3'd0) ? base : ((base + 16'h0020) << (d[6:4] - 3'd1));
            neg = ~d[7];
        end else begin
            d = ~c;
            base = {11'h000, d[3:0], 1'b1};
            t = ((base + 16'h0020) << d[6:4]) - `SPC_MULAW_BIAS;
            neg = d[7];
        end
        spc_expand = neg ? (~t + 16'h0001) : t;
    endfunction

    function automatic logic [15:0] spc_fill(input logic [15:0] w, input logic [3:0] len,
                                             input logic sext);
        logic [15:0] mask;
        mask = 16'hffff >> (4'd15 - len);
        spc_fill = w & mask;
        if (sext && w[len]) spc_fill = spc_fill | ~mask;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [1:0][15:0] sc_reg;
    logic [1:0][15:0] ab_reg;
    logic [1:0][15:0] txd_reg;
    logic [1:0][15:0] rxd_reg;
    logic [1:0] cmp_pend_reg;
    logic [1:0] exp_pend_reg;
    logic [1:0] rx_hw_reg;
    logic [1:0] tx_full_reg;
    logic [3:0] ab_req_reg;
    logic [3:0] ab_req_next;
    logic [1:0] ch_reg;
    spc_ab_state_t st_reg;
    logic ready_reg;
    logic slverr_reg;
    logic [31:0] prdata_reg;

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    wire [13:0] idx = paddr[15:2];
    wire apb_acc = psel && penable;
    wire apb_wr = apb_acc && ready_reg && pwrite;
    wire [1:0] hit_sc = {idx == `SPC_IDX_SC1, idx == `SPC_IDX_SC0}; // [R3]
    wire [1:0] hit_ab = {idx == `SPC_IDX_AB1, idx == `SPC_IDX_AB0}; // [R21]
    wire [1:0] hit_tx = {idx == `SPC_IDX_TX1, idx == `SPC_IDX_TX0};
    wire [1:0] hit_rx = {idx == `SPC_IDX_RX1, idx == `SPC_IDX_RX0};
    wire hit_st = idx == `SPC_IDX_STAT;
    wire mapped = (|hit_sc) || (|hit_ab) || (|hit_tx) || (|hit_rx) || hit_st;
    wire [1:0] wr_tx = {2{apb_wr}} & hit_tx;
    wire [1:0] wr_rx = {2{apb_wr}} & hit_rx;

    // Per-port mode wires; format code 1x companding, x1 A-law or sign extend
    wire [1:0][1:0] fmt = {sc_reg[1][`SPC_SC_FMT_MSB:`SPC_SC_FMT_LSB],
                           sc_reg[0][`SPC_SC_FMT_MSB:`SPC_SC_FMT_LSB]}; // [R4]
    wire [1:0] comp = {fmt[1][1], fmt[0][1]};
    wire [1:0] law_a = {fmt[1][0], fmt[0][0]}; // [R2]
    wire [1:0] rx_en = {ab_reg[1][`SPC_AB_RX_EN], ab_reg[0][`SPC_AB_RX_EN]};
    wire [1:0] tx_en = {ab_reg[1][`SPC_AB_TX_EN], ab_reg[0][`SPC_AB_TX_EN]};

    // ----------------------------------------------------------------
    // Shared compressor and expander
    // ----------------------------------------------------------------
    // Port zero always wins, so port one waits until port zero has nothing pending
    wire [1:0] cmp_gnt = {cmp_pend_reg[1] && !cmp_pend_reg[0], cmp_pend_reg[0]}; // [R1]
    wire [1:0] exp_gnt = {exp_pend_reg[1] && !exp_pend_reg[0], exp_pend_reg[0]}; // [R1]
    wire cmp_p = cmp_gnt[1];
    wire exp_p = exp_gnt[1];
    wire [7:0] cmp_code = spc_compress(txd_reg[cmp_p], law_a[cmp_p]); // [R7]
    wire [15:0] cmp_word = {{8{cmp_code[7]}}, cmp_code}; // [R7]
    wire [15:0] exp_word = spc_expand(rxd_reg[exp_p][7:0], law_a[exp_p]); // [R6]

    // ----------------------------------------------------------------
    // Transmit and receive data paths
    // ----------------------------------------------------------------
    wire ab_done = (st_reg == SPC_AB_WAIT) && dm_ack.ack;
    wire [1:0] ab_tx_ld = {2{ab_done && !ch_reg[0]}} & {ch_reg[1], !ch_reg[1]};
    wire [1:0] ab_rx_st = {2{ab_done && ch_reg[0]}} & {ch_reg[1], !ch_reg[1]};
    wire [1:0] tx_set = wr_tx | ab_tx_ld;
    wire [1:0] cmp_set = tx_set & comp;
    wire [1:0] exp_set = (wr_rx | rx_done) & comp;
    // A word leaves only once compression is written back
    wire [1:0] tx_move = tx_load & tx_full_reg & ~cmp_pend_reg; // [R9]
    // Hardware receive finishes after expansion, so contention only delays it
    wire [1:0] rx_fin = (rx_done & ~comp) | (exp_gnt & rx_hw_reg); // [R12] [R13]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txd_reg <= '0;
            rxd_reg <= '0;
            cmp_pend_reg <= 2'h0;
            exp_pend_reg <= 2'h0;
            rx_hw_reg <= 2'h0;
            tx_full_reg <= 2'h0;
            tx_word <= '0;
            tx_word_valid <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_tx[i]) begin
                    txd_reg[i] <= pwdata[15:0];
                end else if (ab_tx_ld[i]) begin
                    txd_reg[i] <= dm_ack.rdata;
                end else if (cmp_gnt[i]) begin
                    txd_reg[i] <= cmp_word; // [R9] [R14]
                end
                if (wr_rx[i]) begin
                    rxd_reg[i] <= pwdata[15:0];
                end else if (rx_done[i]) begin
                    rxd_reg[i] <= comp[i] ? rx_word[i] :
                        spc_fill(rx_word[i], sc_reg[i][`SPC_SC_LEN_MSB:`SPC_SC_LEN_LSB],
                                 fmt[i][0]); // [R5]
                end else if (exp_gnt[i]) begin
                    rxd_reg[i] <= exp_word; // [R6] [R14]
                end
                tx_word[i] <= tx_move[i] ? txd_reg[i] : tx_word[i];
            end
            // Setting wins over the clear by the grant
            cmp_pend_reg <= (cmp_pend_reg & ~cmp_gnt) | cmp_set;
            exp_pend_reg <= (exp_pend_reg & ~exp_gnt) | exp_set;
            rx_hw_reg <= (rx_hw_reg & ~exp_gnt & ~wr_rx) | (rx_done & comp);
            tx_full_reg <= (tx_full_reg & ~tx_move) | tx_set; // [R10]
            tx_word_valid <= tx_move;
        end
    end

    // ----------------------------------------------------------------
    // Autobuffer arbitration and transfer
    // ----------------------------------------------------------------
    // Channel order 0..3: port0 tx, port0 rx, port1 tx, port1 rx
    wire [3:0] ab_en = {rx_en[1], tx_en[1], rx_en[0], tx_en[0]};
    wire [3:0] ab_set = {rx_fin[1] && rx_en[1], tx_msb_sent[1] && tx_en[1],
                         rx_fin[0] && rx_en[0], tx_msb_sent[0] && tx_en[0]}; // [R15]
    wire [1:0] ab_pick = ab_req_reg[0] ? 2'd0 : ab_req_reg[1] ? 2'd1 :
                         ab_req_reg[2] ? 2'd2 : 2'd3; // [R20]
    // Memory DMA and unfinished instructions hold the transfer off
    wire ab_start = (st_reg == SPC_AB_IDLE) && (|ab_req_reg) && ab_ok && !dma_busy; // [R17] [R20]
    wire [3:0] ab_clr = {4{ab_done}} & (4'h1 << ch_reg);
    wire [15:0] ab_cur = ab_reg[ch_reg[1]];
    wire [2:0] ab_isel = ch_reg[0] ? ab_cur[`SPC_AB_RXI_MSB:`SPC_AB_RXI_LSB] :
                                     ab_cur[`SPC_AB_TXI_MSB:`SPC_AB_TXI_LSB];
    wire [1:0] ab_msel = ch_reg[0] ? ab_cur[`SPC_AB_RXM_MSB:`SPC_AB_RXM_LSB] :
                                     ab_cur[`SPC_AB_TXM_MSB:`SPC_AB_TXM_LSB];

    assign ab_req_next = ((ab_req_reg & ~ab_clr) | ab_set) & ab_en; // [R23]
    assign dm_req_valid = (st_reg == SPC_AB_WAIT); // [R16]
    assign dm_req.we = ch_reg[0]; // [R15]
    assign dm_req.index_sel = ab_isel; // [R22]
    assign dm_req.modify_sel = {ab_isel[2], ab_msel}; // [R22]
    assign dm_req.wdata = rxd_reg[ch_reg[1]];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= SPC_AB_IDLE;
            ch_reg <= 2'd0;
            ab_req_reg <= 4'h0;
        end else begin
            ab_req_reg <= ab_req_next;
            case (st_reg)
                SPC_AB_IDLE: begin
                    if (ab_start) begin
                        st_reg <= SPC_AB_WAIT;
                        ch_reg <= ab_pick;
                    end
                end
                SPC_AB_WAIT: begin
                    if (dm_ack.ack) st_reg <= SPC_AB_IDLE; // [R16]
                end
                default: st_reg <= SPC_AB_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Port interrupts
    // ----------------------------------------------------------------
    // Per-word interrupts vanish under autobuffering; only a wrap signals
    wire [1:0] wrap_tx = ab_tx_ld & {2{dm_ack.wrap}}; // [R18] [R19]
    wire [1:0] wrap_rx = ab_rx_st & {2{dm_ack.wrap}}; // [R18] [R19]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_irq <= 2'h0;
            rx_irq <= 2'h0;
        end else begin
            tx_irq <= (tx_msb_sent & ~tx_en) | wrap_tx; // [R10] [R15]
            rx_irq <= (rx_fin & ~rx_en) | wrap_rx; // [R12] [R15]
        end
    end

    // ----------------------------------------------------------------
    // APB registers
    // ----------------------------------------------------------------
    wire [15:0] stat_val = {5'h00, dm_req_valid, ab_req_reg, exp_pend_reg, cmp_pend_reg,
                            tx_full_reg};
    wire [15:0] rd_val = hit_sc[0] ? sc_reg[0] : hit_sc[1] ? sc_reg[1] :
                         hit_ab[0] ? ab_reg[0] : hit_ab[1] ? ab_reg[1] :
                         hit_tx[0] ? txd_reg[0] : hit_tx[1] ? txd_reg[1] :
                         hit_rx[0] ? rxd_reg[0] : hit_rx[1] ? rxd_reg[1] :
                         hit_st ? stat_val : 16'h0000;

    assign pready = ready_reg;
    assign pslverr = slverr_reg;
    assign prdata = prdata_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_reg <= 1'b0;
            slverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            ready_reg <= apb_acc && !ready_reg;
            slverr_reg <= apb_acc && !ready_reg && !mapped;
            if (apb_acc && !ready_reg) prdata_reg <= {16'h0000, rd_val};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sc_reg <= {`SPC_SC_RESET, `SPC_SC_RESET};
            ab_reg <= {`SPC_AB_RESET, `SPC_AB_RESET};
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (apb_wr && hit_sc[i]) sc_reg[i] <= pwdata[15:0];
                if (reboot) begin
                    ab_reg[i][`SPC_AB_RX_EN] <= 1'b0; // [R23]
                    ab_reg[i][`SPC_AB_TX_EN] <= 1'b0; // [R23]
                end else if (apb_wr && hit_ab[i]) begin
                    ab_reg[i] <= pwdata[15:0]; // [R21]
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_cmp_port_wait: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        cmp_pend_reg == 2'b11 && !cmp_set[0] |=> cmp_pend_reg == 2'b10)
        else $error("port one compression not delayed by one cycle");
    a_exp_port_wait: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        exp_pend_reg == 2'b10 && exp_set == 2'b00 |=> exp_pend_reg == 2'b00)
        else $error("port one expansion not served");
    a_tx_readback: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
        wr_tx[0] && comp[0] |=> ##1 txd_reg[0][15:8] == {8{txd_reg[0][7]}})
        else $error("compressed transmit value not in place after one cycle");
    a_rx_irq_after: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        rx_done[0] && comp[0] && !rx_en[0] |=> !rx_irq[0])
        else $error("receive interrupt raised before expansion");
    a_tx_irq_msb: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        tx_msb_sent[0] && !tx_en[0] |=> tx_irq[0])
        else $error("transmit interrupt missing after first bit");
    a_dm_req_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
        dm_req_valid && !dm_ack.ack |=> dm_req_valid && $stable(dm_req))
        else $error("autobuffer request dropped during wait states");
    a_ab_start_ok: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
        $rose(dm_req_valid) |-> $past(ab_ok) && !$past(dma_busy))
        else $error("autobuffer transfer started mid instruction");
    a_ab_priority: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
        ab_start && ab_req_reg[0] |=> dm_req_valid && ch_reg == 2'd0 && !dm_req.we)
        else $error("port zero transmit not served first");
    a_rx_wrap_irq: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
        ab_done && ch_reg == 2'd3 && dm_ack.wrap |=> rx_irq[1])
        else $error("receive wrap interrupt missing");
    a_reboot_clear: assert property (@(posedge clk) disable iff (!rst_n) // [R23]
        reboot |=> !tx_en[0] && !rx_en[0] && !tx_en[1] && !rx_en[1])
        else $error("autobuffer enables survive reboot");
    a_modify_bank: assert property (@(posedge clk) disable iff (!rst_n) // [R22]
        dm_req_valid |-> dm_req.modify_sel[2] == dm_req.index_sel[2])
        else $error("modify register outside index bank");

endmodule // spc_compand_autobuf

// ---- spc_dm_model.sv ----
`timescale 1ns/1ps
module spc_dm_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request from the block
    input wire logic dm_req_valid,
    input wire spc_pkg::spc_dm_req_t dm_req,
    // Behaviour chosen by the bench
    input wire logic [3:0] wait_cycles,
    input wire logic wrap_flag,
    input wire logic [15:0] tx_data,
    // Answer
    output spc_pkg::spc_dm_ack_t dm_ack
);
    import spc_pkg::*;
    logic [3:0] cnt_reg;
    logic [15:0] bus_reg;
    logic ack_now;
    // The answer stands in the cycle in which the wait states have run out
    assign ack_now = dm_req_valid && cnt_reg == wait_cycles;
    // Outside an answer the data bus toggles, so a stale word is never mistaken for a read
    assign dm_ack = '{ack: ack_now, wrap: ack_now && wrap_flag,
                      rdata: (ack_now && !dm_req.we) ? tx_data : bus_reg};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 4'h0;
            bus_reg <= 16'h0000;
        end else begin
            cnt_reg <= (dm_req_valid && !ack_now) ? cnt_reg + 4'h1 : 4'h0;
            bus_reg <= ~bus_reg;
        end
    end
endmodule // spc_dm_model

// ---- serial_port_compand_autobuffer_tb.sv ----
`timescale 1ns/1ps
`include "spc_regs.svh"
module serial_port_compand_autobuffer_tb;
    import spc_pkg::*;
    logic clk, rst_n, reboot, psel, penable, pwrite, ab_ok, dma_busy, pm_wrap;
    logic pready, pslverr, dm_req_valid;
    logic [15:0] paddr, pm_data;
    logic [31:0] pwdata, prdata;
    logic [1:0] tx_load, tx_msb_sent, tx_word_valid, rx_done, tx_irq, rx_irq;
    logic [1:0][15:0] tx_word, rx_word;
    logic [3:0] pm_wait;
    logic [7:0] b;
    spc_dm_req_t dm_req;
    spc_dm_ack_t dm_ack;
    logic [32:0] rdq[$];
    logic [15:0] txq[$];
    logic [15:0] tab_idx[4] = '{`SPC_IDX_TX0, `SPC_IDX_TX0, `SPC_IDX_TX1, `SPC_IDX_TX1};
    logic [15:0] tab_in[4] = '{16'h7fff, 16'h8000, 16'h7fff, 16'h8000};
    logic [15:0] tab_ex[4] = '{16'hff80, 16'h0000, 16'hffaa, 16'h002a};
    int err_count = 0, checked = 0, seed = 66471, txi = 0, vcnt = 0, n;

    spc_compand_autobuf spc_compand_autobuf_inst (.clk, .rst_n, .reboot, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_load, .tx_msb_sent,
        .tx_word_valid, .tx_word, .rx_done, .rx_word, .tx_irq, .rx_irq, .ab_ok, .dma_busy,
        .dm_req_valid, .dm_req, .dm_ack);
    spc_dm_model spc_dm_model_inst (.clk, .rst_n, .dm_req_valid, .dm_req,
        .wait_cycles(pm_wait), .wrap_flag(pm_wrap), .tx_data(pm_data), .dm_ack);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("Mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // One idle cycle after each transfer keeps psel from being driven twice in a step
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx[13:0], 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [15:0] v, input logic e);
        rdq.push_back({e, 16'h0000, v});
        apb(1'b0, idx, 16'h0000);
    endtask

    // Receive a word and measure cycles until each port's interrupt
    task automatic rx(input logic [1:0] p, input logic [15:0] w, input int l0, input int l1);
        int f0, f1;
        f0 = 0;
        f1 = 0;
        rx_word <= {w, w};
        rx_done <= p;
        @(posedge clk);
        rx_done <= 2'b00;
        #1;
        for (int i = 1; i < 6; i++) begin
            if (rx_irq[0] === 1'b1 && f0 == 0) f0 = i;
            if (rx_irq[1] === 1'b1 && f1 == 0) f1 = i;
            @(posedge clk);
            #1;
        end
        check(33'(f0), 33'(l0));
        check(33'(f1), 33'(l1));
    endtask

    task automatic msb_sent;
        tx_msb_sent <= 2'b01;
        @(posedge clk);
        tx_msb_sent <= 2'b00;
    endtask

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({pslverr, prdata}, rdq.pop_front());
        end
        if (tx_word_valid[0] === 1'b1) begin
            check({17'h0, tx_word[0]}, {17'h0, txq.pop_front()});
        end
        if (tx_irq[0] === 1'b1) txi++;
        if (dm_req_valid === 1'b1) vcnt++;
    end

    initial begin
        {rst_n, reboot, psel, penable, pwrite, dma_busy, pm_wrap} = '0;
        {paddr, pwdata, pm_data, tx_load, tx_msb_sent, rx_done, rx_word} = '0;
        ab_ok = 1'b1;
        pm_wait = 4'h2;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(`SPC_IDX_AB0, 16'h0000, 1'b0);
        rd(`SPC_IDX_AB1, 16'h0000, 1'b0);
        rd(`SPC_IDX_SC1, 16'h0000, 1'b0);
        rd(16'h0000, 16'h0000, 1'b1);
        for (int f = 0; f < 2; f++) begin
            b = 8'h80 | 8'($random(seed));
            apb(1'b1, `SPC_IDX_SC0, {10'h0, 2'(f), 4'h7});
            rx(2'b01, {8'h00, b}, 1, 0);
            rd(`SPC_IDX_RX0, {{8{f[0]}}, b}, 1'b0);
        end
        apb(1'b1, `SPC_IDX_SC0, 16'h0027);
        apb(1'b1, `SPC_IDX_SC1, 16'h0037);
        rx(2'b11, 16'h0055, 2, 3);
        rd(`SPC_IDX_RX0, 16'hff4d, 1'b0);
        rd(`SPC_IDX_RX1, 16'hffff, 1'b0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, tab_idx[i], tab_in[i]);
            rd(tab_idx[i], tab_ex[i], 1'b0);
        end
        apb(1'b1, `SPC_IDX_SC0, 16'h0007);
        apb(1'b1, `SPC_IDX_TX0, 16'h00a5);
        txq.push_back(16'h00a5);
        tx_load <= 2'b01;
        @(posedge clk);
        tx_load <= 2'b00;
        txi = 0;
        msb_sent();
        repeat (3) @(posedge clk);
        check(33'(txi), 33'd1);
        apb(1'b1, `SPC_IDX_AB0, 16'h0a82);
        rd(`SPC_IDX_AB0, 16'h0a82, 1'b0);
        for (int w = 0; w < 2; w++) begin
            pm_data <= 16'($random(seed));
            pm_wrap <= w[0];
            ab_ok <= w[0];
            dma_busy <= w[0];
            txi = 0;
            msb_sent();
            repeat (4) @(posedge clk);
            check(33'(dm_req_valid), 33'd0);
            ab_ok <= 1'b1;
            dma_busy <= 1'b0;
            vcnt = 0;
            n = 0;
            while (dm_ack.ack !== 1'b1 && n < 30) begin
                @(posedge clk);
                n++;
            end
            if (n == 30) err_count++;
            check({dm_req.we, dm_req.index_sel, dm_req.modify_sel}, 33'h2e);
            txq.push_back(pm_data);
            @(posedge clk);
            check(33'(vcnt), 33'd3);
            tx_load <= 2'b01;
            @(posedge clk);
            tx_load <= 2'b00;
            repeat (3) @(posedge clk);
            check(33'(txi), 33'(w));
        end
        reboot <= 1'b1;
        @(posedge clk);
        reboot <= 1'b0;
        rd(`SPC_IDX_AB0, 16'h0a80, 1'b0);
        txi = 0;
        vcnt = 0;
        msb_sent();
        repeat (4) @(posedge clk);
        check(33'(txi), 33'd1);
        check(33'(vcnt), 33'd0);
        print_verdict();
    end

    initial begin
        #40000;
        err_count++;
        print_verdict();
    end
endmodule // serial_port_compand_autobuffer_tb
